// ### inc/uart_task_event_pkg.sv
// Constants, register map and carrier types for the UART task and event block.
// Assumes a 32-bit AHB-Lite register bus with word-aligned single transfers.
package uart_task_event_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CH_W = 8;
    localparam int unsigned NUM_TASKS = 5;
    localparam int unsigned NUM_EVENTS = 5;

    // ------------------------------------------------------------------
    // Task and event indices (bit positions in vectors)
    // ------------------------------------------------------------------
    localparam int unsigned TASK_START_RX = 0;
    localparam int unsigned TASK_STOP_RX = 1;
    localparam int unsigned TASK_START_TX = 2;
    localparam int unsigned TASK_STOP_TX = 3;
    localparam int unsigned TASK_FLUSH_RX = 4;

    localparam int unsigned EVT_CTS = 0;
    localparam int unsigned EVT_NCTS = 1;
    localparam int unsigned EVT_RX_BYTE = 2;
    localparam int unsigned EVT_RX_FULL = 3;
    localparam int unsigned EVT_TX_BYTE = 4;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] TASK_OFF [NUM_TASKS] =
        '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h02C};
    localparam logic [ADDR_W-1:0] SUB_OFF [NUM_TASKS] =
        '{12'h080, 12'h084, 12'h088, 12'h08C, 12'h0AC};
    localparam logic [ADDR_W-1:0] EVT_OFF [NUM_EVENTS] =
        '{12'h100, 12'h104, 12'h108, 12'h110, 12'h11C};
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFF = 12'h400;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFF = 12'h404;
    localparam logic [ADDR_W-1:0] RUN_STATE_OFF = 12'h408;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned TRIGGER_BIT = 0;
    localparam int unsigned EVT_BIT = 0;
    localparam int unsigned SUB_EN_BIT = 31;
    localparam int unsigned RUN_RX_BIT = 0;
    localparam int unsigned RUN_TX_BIT = 1;
    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [NUM_EVENTS-1:0] EVT_ZERO = 5'h00;
    localparam logic [NUM_TASKS-1:0] TASK_ZERO = 5'h00;

    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    // One subscription register: enable and fabric channel index
    typedef struct packed {
        logic en;
        logic [CH_W-1:0] channel_index;
    } sub_t;

    // One pulse on the event channel fabric
    typedef struct packed {
        logic valid;
        logic [CH_W-1:0] channel_index;
    } fabric_pulse_t;

    // Bus slave data-phase states
    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_WRITE,
        BUS_READ_WAIT,
        BUS_READ_DONE
    } bus_state_t;

endpackage

// ### rtl/uart_task_event_regs.sv
// Task, subscription and event registers of a DMA-capable UART, on AHB-Lite.
// Assumes the receiver, transmitter and DMA logic sit on hclk and deliver
// their events as one-cycle pulses; the clear-to-send pin is asynchronous.
//
// How it works
// [RULE_01] Writing 1 to bit 0 at 0x000 starts the receiver.
// [RULE_02] Writing 1 to bit 0 at 0x004 stops the receiver.
// [RULE_03] Writing 1 to bit 0 at 0x008 starts the transmitter.
// [RULE_04] Writing 1 to bit 0 at 0x00C stops the transmitter.
// [RULE_05] Flush task at 0x02C moves leftover FIFO bytes into memory buffer.
// [RULE_06] Each task has a subscription whose low 8 bits pick a fabric channel.
// [RULE_07] Subscription enable bit gates fabric triggering: 0 off, 1 on.
// [RULE_08] Stop-receive subscription at 0x084, stop-transmit at 0x08C.
// [RULE_09] Start-transmit subscription at 0x088, flush-receive at 0x0AC.
// [RULE_10] Clear-to-send pin falling sets the event at 0x100.
// [RULE_11] Clear-to-send pin rising sets the event at 0x104.
// [RULE_12] Byte landed in receive holding register raises receive-ready event.
// [RULE_13] Receive buffer completely filled raises event at 0x110.
// [RULE_14] Byte sent from transmit register raises event at 0x11C.
// [RULE_15] Event registers read/write in bit 0, reset to zero.
// [RULE_16] Writing 0 clears an event; writing 0 to a task does nothing.
// [RULE_17] An event coinciding with a clearing write wins and stays set.
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps

module uart_task_event_regs
    import uart_task_event_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [DATA_W-1:0] hrdata,
    // Event channel fabric
    input wire fabric_pulse_t fabric_pulse,
    // Clear-to-send pin, active low, asynchronous
    input wire logic clear_to_send_n,
    // Event pulses from receiver, DMA and transmitter
    input wire logic rx_byte_received,
    input wire logic rx_buffer_filled,
    input wire logic tx_byte_sent,
    // Task pulses and run state towards the UART core
    output logic [NUM_TASKS-1:0] task_fire,
    output logic rx_enabled,
    output logic tx_enabled,
    // Interrupt
    output logic irq
);

    // ------------------------------------------------------------------
    // Bus slave front end
    // ------------------------------------------------------------------
    bus_state_t bus_state;
    bus_state_t next_bus_state;
    logic [ADDR_W-1:0] addr_q;
    wire logic accept;
    wire logic accept_write;
    wire logic accept_read;
    wire logic wr_en;
    wire logic rd_capture;

    // Address phase is taken only for a selected, active, ready transfer
    assign accept = hsel && hready && htrans[1];
    assign accept_write = accept && hwrite;
    assign accept_read = accept && !hwrite;
    assign wr_en = (bus_state == BUS_WRITE);
    assign rd_capture = (bus_state == BUS_READ_WAIT);

    // Reads take one wait state so read data always comes from a flop and
    // a write in the previous data phase is already visible
    assign hreadyout = (bus_state != BUS_READ_WAIT);
    assign hresp = HRESP_OKAY;

    // Next bus state
    always_comb begin
        next_bus_state = bus_state;
        case (bus_state)
            BUS_READ_WAIT: begin
                next_bus_state = BUS_READ_DONE;
            end
            default: begin
                if (accept_write) begin
                    next_bus_state = BUS_WRITE;
                end else if (accept_read) begin
                    next_bus_state = BUS_READ_WAIT;
                end else begin
                    next_bus_state = BUS_IDLE;
                end
            end
        endcase
    end

    // Bus state and captured address
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_state <= BUS_IDLE;
            addr_q <= '0;
        end else begin
            bus_state <= next_bus_state;
            if (accept) begin
                addr_q <= haddr[ADDR_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic [NUM_TASKS-1:0] wr_task;
    logic [NUM_TASKS-1:0] wr_sub;
    logic [NUM_EVENTS-1:0] wr_evt;
    wire logic wr_mask;
    wire logic rd_status;

    for (genvar i = 0; i < NUM_TASKS; i++) begin : g_task_decode
        // [RULE_01] trigger on one
        // [RULE_02] trigger on one
        // [RULE_03] trigger on one
        // [RULE_04] trigger on one
        // [RULE_05] flush trigger, data moved by DMA
        // [RULE_16] zero is ignored
        assign wr_task[i] = wr_en && (addr_q == TASK_OFF[i]) && hwdata[TRIGGER_BIT];
        // [RULE_08] subscription offsets
        // [RULE_09] subscription offsets
        assign wr_sub[i] = wr_en && (addr_q == SUB_OFF[i]);
    end

    for (genvar i = 0; i < NUM_EVENTS; i++) begin : g_evt_decode
        assign wr_evt[i] = wr_en && (addr_q == EVT_OFF[i]);
    end

    assign wr_mask = wr_en && (addr_q == IRQ_MASK_OFF);
    // Status clears on the cycle its read data is captured
    assign rd_status = rd_capture && (addr_q == IRQ_STATUS_OFF);

    // ------------------------------------------------------------------
    // Subscriptions and task triggering
    // ------------------------------------------------------------------
    sub_t sub [NUM_TASKS];
    logic [NUM_TASKS-1:0] fabric_hit;
    logic [NUM_TASKS-1:0] task_req;

    for (genvar i = 0; i < NUM_TASKS; i++) begin : g_sub
        // [RULE_06] channel match
        // [RULE_07] enable gates fabric
        assign fabric_hit[i] = fabric_pulse.valid && sub[i].en
            && (fabric_pulse.channel_index == sub[i].channel_index);
        assign task_req[i] = wr_task[i] || fabric_hit[i];

        // Subscription register, reserved bits are not stored
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                sub[i] <= '0;
            end else if (wr_sub[i]) begin
                sub[i].en <= hwdata[SUB_EN_BIT];
                sub[i].channel_index <= hwdata[CH_W-1:0];
            end
        end
    end

    // Task pulses out, one cycle each, registered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            task_fire <= TASK_ZERO;
        end else begin
            task_fire <= task_req;
        end
    end

    // ------------------------------------------------------------------
    // Run state of receiver and transmitter
    // ------------------------------------------------------------------
    // A stop in the same cycle as a start wins, so the link is never left
    // running by a race between software and the fabric.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_enabled <= 1'b0;
            tx_enabled <= 1'b0;
        end else begin
            // [RULE_02] stop receiver
            if (task_fire[TASK_STOP_RX]) begin
                rx_enabled <= 1'b0;
            // [RULE_01] start receiver
            end else if (task_fire[TASK_START_RX]) begin
                rx_enabled <= 1'b1;
            end
            // [RULE_04] stop transmitter
            if (task_fire[TASK_STOP_TX]) begin
                tx_enabled <= 1'b0;
            // [RULE_03] start transmitter
            end else if (task_fire[TASK_START_TX]) begin
                tx_enabled <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Clear-to-send synchroniser and edge detect
    // ------------------------------------------------------------------
    // Resets high, the inactive level, so no false edge after reset
    logic cts_meta;
    logic cts_sync;
    logic cts_prev;
    wire logic cts_fall;
    wire logic cts_rise;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cts_meta <= 1'b1;
            cts_sync <= 1'b1;
            cts_prev <= 1'b1;
        end else begin
            cts_meta <= clear_to_send_n;
            cts_sync <= cts_meta;
            cts_prev <= cts_sync;
        end
    end

    // [RULE_10] active going low
    assign cts_fall = cts_prev && !cts_sync;
    // [RULE_11] inactive going high
    assign cts_rise = !cts_prev && cts_sync;

    // ------------------------------------------------------------------
    // Event registers
    // ------------------------------------------------------------------
    logic [NUM_EVENTS-1:0] evt_set;
    logic [NUM_EVENTS-1:0] evt_flag;
    logic [NUM_EVENTS-1:0] next_evt_flag;

    // [RULE_12] receive byte ready
    // [RULE_13] buffer filled
    // [RULE_14] byte sent
    assign evt_set[EVT_CTS] = cts_fall;
    assign evt_set[EVT_NCTS] = cts_rise;
    assign evt_set[EVT_RX_BYTE] = rx_byte_received;
    assign evt_set[EVT_RX_FULL] = rx_buffer_filled;
    assign evt_set[EVT_TX_BYTE] = tx_byte_sent;

    for (genvar i = 0; i < NUM_EVENTS; i++) begin : g_evt
        // [RULE_16] write stores bit 0
        // [RULE_17] hardware set wins
        assign next_evt_flag[i] = evt_set[i]
            || (wr_evt[i] ? hwdata[EVT_BIT] : evt_flag[i]);
    end

    // [RULE_15] event flags reset to zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_flag <= EVT_ZERO;
        end else begin
            evt_flag <= next_evt_flag;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status, mask and output
    // ------------------------------------------------------------------
    // Status is a separate sticky copy so that software clearing an event
    // register does not also lose a pending interrupt, and vice versa.
    logic [NUM_EVENTS-1:0] irq_status;
    logic [NUM_EVENTS-1:0] irq_mask;
    wire logic [NUM_EVENTS-1:0] next_irq_status;

    // Read clears, but a new event in that cycle stays pending
    assign next_irq_status = evt_set | (rd_status ? EVT_ZERO : irq_status);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= EVT_ZERO;
            irq_mask <= EVT_ZERO;
            irq <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            if (wr_mask) begin
                irq_mask <= hwdata[NUM_EVENTS-1:0];
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Task registers are write-only and read as zero, as do unmapped words
    logic [DATA_W-1:0] rd_mux;

    always_comb begin
        rd_mux = WORD_ZERO;
        if (addr_q == IRQ_STATUS_OFF) begin
            rd_mux[NUM_EVENTS-1:0] = irq_status;
        end else if (addr_q == IRQ_MASK_OFF) begin
            rd_mux[NUM_EVENTS-1:0] = irq_mask;
        end else if (addr_q == RUN_STATE_OFF) begin
            rd_mux[RUN_RX_BIT] = rx_enabled;
            rd_mux[RUN_TX_BIT] = tx_enabled;
        end else begin
            for (int k = 0; k < NUM_TASKS; k++) begin
                if (addr_q == SUB_OFF[k]) begin
                    rd_mux[SUB_EN_BIT] = sub[k].en;
                    rd_mux[CH_W-1:0] = sub[k].channel_index;
                end
            end
            // [RULE_15] event bit 0 readable
            for (int k = 0; k < NUM_EVENTS; k++) begin
                if (addr_q == EVT_OFF[k]) begin
                    rd_mux[EVT_BIT] = evt_flag[k];
                end
            end
        end
    end

    // Read data register, loaded in the wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= WORD_ZERO;
        end else if (rd_capture) begin
            hrdata <= rd_mux;
        end
    end

endmodule

// ### tb/uart_task_event_assertions.sv
// Concurrent checks on the ports of the task and event register block.
// Assumes one AHB-Lite master, with hready tied to hreadyout.
`timescale 1ns/1ps
module uart_task_event_checker
    import uart_task_event_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Register bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [DATA_W-1:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [DATA_W-1:0] hrdata,
    // Core side
    input wire logic [NUM_TASKS-1:0] task_fire,
    input wire logic rx_enabled,
    input wire logic tx_enabled,
    input wire logic irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Address phase accepted by the slave
    wire logic take = hsel && hready && htrans[1];
    // -------------------------------------------------------------
    // Tasks and bus timing
    // -------------------------------------------------------------
    // start receive write
    a_start_rx_write: assert property (take && hwrite && haddr[11:0] == 12'h000
        ##1 hwdata[0] |=> task_fire[TASK_START_RX]) else $error("start rx write lost");
    a_stop_tx_write: assert property (take && hwrite && haddr[11:0] == 12'h00C
        ##1 hwdata[0] |=> task_fire[TASK_STOP_TX]) else $error("stop tx write lost");
    a_flush_write: assert property (take && hwrite && haddr[11:0] == 12'h02C
        ##1 hwdata[0] |=> task_fire[TASK_FLUSH_RX]) else $error("flush write lost");
    a_rx_runs: assert property (task_fire[0] && !task_fire[1] |=> rx_enabled)
        else $error("receiver did not start");
    a_rx_halts: assert property (task_fire[1] |=> !rx_enabled)
        else $error("receiver did not stop");
    a_tx_runs: assert property (task_fire[2] && !task_fire[3] |=> tx_enabled)
        else $error("transmitter did not start");
    a_tx_halts: assert property (task_fire[3] |=> !tx_enabled)
        else $error("transmitter did not stop");
    a_flush_reads_zero: assert property (take && !hwrite && haddr[11:0] == 12'h02C
        |=> ##1 hrdata == WORD_ZERO) else $error("write-only task read nonzero");
    a_read_one_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_no_wait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    a_resp_okay: assert property (hresp == HRESP_OKAY)
        else $error("response not okay");
    // Main scenarios reached
    c_rx_on: cover property ($rose(rx_enabled));
    c_irq_up: cover property ($rose(irq));
    c_flush: cover property (task_fire[TASK_FLUSH_RX]);
endmodule

bind uart_task_event_regs uart_task_event_checker u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .task_fire(task_fire), .rx_enabled(rx_enabled),
    .tx_enabled(tx_enabled), .irq(irq)
);

// ### tb/uart_far_model.sv
// Far side of the link: remote flow-control pin and core event pulses.
// Assumes callers enter raise just after a rising hclk edge.
`timescale 1ns/1ps
module uart_far_model (
    // Clock
    input wire logic hclk,
    // Towards the block
    output logic clear_to_send_n,
    output logic rx_byte_received,
    output logic rx_buffer_filled,
    output logic tx_byte_sent
);
    // Pin idles high so no edge event fires out of reset
    initial begin
        clear_to_send_n = 1'b1;
        rx_byte_received = 1'b0;
        rx_buffer_filled = 1'b0;
        tx_byte_sent = 1'b0;
    end
    // Event i for one cycle; 0 and 1 move the pin as a level
    task automatic raise(input int i);
        case (i)
            0: clear_to_send_n <= 1'b0;
            1: clear_to_send_n <= 1'b1;
            2: rx_byte_received <= 1'b1;
            3: rx_buffer_filled <= 1'b1;
            default: tx_byte_sent <= 1'b1;
        endcase
        @(posedge hclk);
        rx_byte_received <= 1'b0;
        rx_buffer_filled <= 1'b0;
        tx_byte_sent <= 1'b0;
    endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the UART task, subscription and event registers.
// Assumes one AHB-Lite master here and the far model on the event inputs.
`timescale 1ns/1ps
module tb_top
    import uart_task_event_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [DATA_W-1:0] hwdata = 32'h0;
    fabric_pulse_t fabric_pulse = 9'h000;
    logic hreadyout, hresp, irq, rx_enabled, tx_enabled, cts_n, rx_b, rx_f, tx_b;
    logic [DATA_W-1:0] hrdata, rd;
    logic [NUM_TASKS-1:0] task_fire;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;
    initial begin
        forever #10 hclk = ~hclk;
    end
    uart_task_event_regs u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fabric_pulse(fabric_pulse),
        .clear_to_send_n(cts_n), .rx_byte_received(rx_b), .rx_buffer_filled(rx_f),
        .tx_byte_sent(tx_b), .task_fire(task_fire), .rx_enabled(rx_enabled),
        .tx_enabled(tx_enabled), .irq(irq)
    );
    uart_far_model u_far (
        .hclk(hclk), .clear_to_send_n(cts_n), .rx_byte_received(rx_b),
        .rx_buffer_filled(rx_f), .tx_byte_sent(tx_b)
    );
    // -------------------------------------------------------------
    // Shared helpers
    // -------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", nm, exp, got);
            miscompares++;
        end
    endtask
    // Ready and read data are taken at the rising edge, before its updates land
    task automatic wt();
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        wt();
        htrans <= 2'h0;
        hwdata <= wd;
        wt();
    endtask
    task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask
    task automatic fire(input logic [7:0] ch);
        fabric_pulse <= {1'b1, ch};
        @(posedge hclk);
        fabric_pulse <= 9'h000;
        #1;
    endtask
    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    task automatic t_reset_map();
        for (int i = 0; i < NUM_TASKS; i++) begin
            rc("task reg", TASK_OFF[i], WORD_ZERO);
            rc("subscription", SUB_OFF[i], WORD_ZERO);
            rc("event reg", EVT_OFF[i], WORD_ZERO);
        end
        rc("unmapped", 12'h200, WORD_ZERO);
        $display("test reset_map done");
    endtask
    task automatic t_tasks();
        logic rx_exp;
        logic tx_exp;
        rx_exp = 1'b0;
        tx_exp = 1'b0;
        for (int i = 0; i < NUM_TASKS; i++) begin
            bus(1'b1, TASK_OFF[i], 32'h1);
            #1 chk("task pulse", 32'(1 << i), 32'(task_fire));
            if (i == TASK_START_RX) rx_exp = 1'b1;
            if (i == TASK_STOP_RX) rx_exp = 1'b0;
            if (i == TASK_START_TX) tx_exp = 1'b1;
            if (i == TASK_STOP_TX) tx_exp = 1'b0;
            @(posedge hclk);
            #1 chk("pulse end", 32'h0, 32'(task_fire));
            chk("rx run", 32'(rx_exp), 32'(rx_enabled));
            chk("tx run", 32'(tx_exp), 32'(tx_enabled));
        end
        bus(1'b1, TASK_OFF[TASK_START_RX], 32'h0);
        #1 chk("zero write", 32'h0, 32'(task_fire));
        rc("run state", RUN_STATE_OFF, 32'h0);
        $display("test tasks done");
    endtask
    // Channels run up to 8'hFF to reach the top of the index field
    task automatic t_subscribe();
        logic [31:0] w;
        for (int i = 0; i < NUM_TASKS; i++) begin
            w = 32'h8000_0000 | 32'(8'hFB + i);
            bus(1'b1, SUB_OFF[i], w);
            rc("subscription", SUB_OFF[i], w);
            fire(8'(8'hFB + i));
            chk("fabric task", 32'(1 << i), 32'(task_fire));
            fire(8'h05);
            chk("other channel", 32'h0, 32'(task_fire));
            bus(1'b1, SUB_OFF[i], w & 32'h0000_00FF);
            fire(8'(8'hFB + i));
            chk("disabled", 32'h0, 32'(task_fire));
        end
        $display("test subscribe done");
    endtask
    // Two of the five events are masked, so irq must follow the mask bit
    task automatic t_events();
        logic [4:0] mask;
        mask = 5'h15;
        bus(1'b1, IRQ_MASK_OFF, 32'(mask));
        rc("mask", IRQ_MASK_OFF, 32'(mask));
        for (int i = 0; i < NUM_EVENTS; i++) begin
            u_far.raise(i);
            repeat (4) @(posedge hclk);
            #1 chk("irq", 32'(mask[i]), 32'(irq));
            rc("event", EVT_OFF[i], 32'h1);
            rc("status", IRQ_STATUS_OFF, 32'(1 << i));
            rc("status cleared", IRQ_STATUS_OFF, 32'h0);
            chk("irq low", 32'h0, 32'(irq));
            bus(1'b1, EVT_OFF[i], 32'h0);
            rc("event cleared", EVT_OFF[i], 32'h0);
        end
        // Pulse lands in the data phase of the clearing write, so both hit one edge
        fork
            bus(1'b1, EVT_OFF[EVT_RX_BYTE], 32'h0);
            begin
                @(posedge hclk);
                u_far.raise(EVT_RX_BYTE);
            end
        join
        rc("event kept", EVT_OFF[EVT_RX_BYTE], 32'h1);
        $display("test events done");
    endtask
    // -------------------------------------------------------------
    // Run control
    // -------------------------------------------------------------
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Run needs well under a thousand cycles; the ceiling leaves margin
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        t_reset_map();
        t_tasks();
        t_subscribe();
        t_events();
        end_sim();
    end
endmodule
